// file: pkg/spicr_consts.svh
// Register map, field positions, reset values and timing counts
`ifndef SPICR_CONSTS_SVH
`define SPICR_CONSTS_SVH
`define SPICR_A_CFG 2'h0
`define SPICR_A_CTRL 2'h1
`define SPICR_A_RATE 2'h2
`define SPICR_A_DATA 2'h3
`define SPICR_B_MASTER 6
`define SPICR_B_CPHA 5
`define SPICR_B_CPOL 4
`define SPICR_B_EN 0
`define SPICR_B_BUSY 1
`define SPICR_B_DONE 2
`define SPICR_RST_CFG 8'h00
`define SPICR_RST_RATE 8'h00
`define SPICR_RST_TX 8'h00
`define SPICR_P_SCK 0
`define SPICR_P_MOSI 1
`define SPICR_P_MISO 2
`define SPICR_P_NSS 3
`define SPICR_SYS_KHZ 250000
`define SPICR_MAX_KHZ 12500
`define SPICR_MIN_HALF ((`SPICR_SYS_KHZ + 2 * `SPICR_MAX_KHZ - 1) / (2 * `SPICR_MAX_KHZ))
`endif

// file: pkg/spicr_pkg.sv
// Shared types of the serial link ends
package spicr_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_run = 3'b010,
    st_tail = 3'b100
  } spicr_state_t;
endpackage

// file: pkg/spicr_if.sv
// Link pins between the peripheral end and the far end
`timescale 1ns/100ps
interface spicr_if;
  // Pin index: 0 clock, 1 master out, 2 master in, 3 select low
  logic [3:0] dev_o;
  logic [3:0] dev_oe_n;
  logic [3:0] oth_o;
  logic [3:0] oth_oe_n;
  logic [3:0] pin;
  // Undriven pins float high through a pull-up
  assign pin = (~dev_oe_n & dev_o) | (~oth_oe_n & oth_o) | (dev_oe_n & oth_oe_n);
  modport dev (output dev_o, output dev_oe_n, input pin);
  modport oth (output oth_o, output oth_oe_n, input pin);
endinterface

// file: verilog/spicr_dev.sv
// Serial peripheral end with clock mode, polarity and rate control
`timescale 1ns/100ps
`include "spicr_consts.svh"
module spicr_dev
  import spicr_pkg::*;
(
  // System
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Link
  spicr_if.dev spi
);
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic sck_prev_q;
  logic nss_prev_q;
  logic [7:0] cfg_q, cfg_d;
  logic en_q, en_d;
  logic [7:0] rate_q, rate_d;
  logic [7:0] txb_q, txb_d;
  logic [7:0] rx_q, rx_d;
  logic done_q, done_d;
  logic [7:0] rdata_q, rdata_d;
  spicr_state_t st_q, st_d;
  logic [8:0] div_q, div_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic out_q, out_d;
  logic sck_q, sck_d;
  logic nss_q, nss_d;
  logic [3:0] oe_n_q, oe_n_d;
  logic cpha;
  logic cpol;
  logic master;
  logic [8:0] half;
  logic [8:0] rate_p1;
  logic din;
  logic edge_ev;
  logic samp;
  logic fin;

  assign cpha = cfg_q[`SPICR_B_CPHA];
  assign cpol = cfg_q[`SPICR_B_CPOL];
  assign master = cfg_q[`SPICR_B_MASTER];
  assign rate_p1 = {1'b0, rate_q} + 9'h001;
  // Floor on the half period keeps the master at or below 12.5 MHz
  assign half = (rate_p1 < 9'(`SPICR_MIN_HALF)) ? 9'(`SPICR_MIN_HALF) : rate_p1;
  assign din = master ? s2_q[`SPICR_P_MISO] : s2_q[`SPICR_P_MOSI];

  // Pins from the far end cross into this clock domain
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      // Matches the pulled-up idle pin, so no false edge after reset
      sck_prev_q <= 1'b1;
      nss_prev_q <= 1'b1;
    end
    else
    begin
      s1_q <= spi.pin;
      s2_q <= s1_q;
      sck_prev_q <= s2_q[`SPICR_P_SCK];
      nss_prev_q <= s2_q[`SPICR_P_NSS];
    end
  end

  // Transfer engine
  always_comb
  begin
    st_d = st_q;
    div_d = div_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    out_d = out_q;
    sck_d = sck_q;
    nss_d = nss_q;
    rx_d = rx_q;
    fin = 1'b0;
    edge_ev = 1'b0;
    // Phase zero samples even (leading) edges, phase one odd ones
    samp = cpha ? cnt_q[0] : ~cnt_q[0];
    case (st_q)
      st_idle:
      begin
        sck_d = cpol;
        nss_d = 1'b1;
        div_d = 9'h000;
        cnt_d = 4'h0;
        if (en_q && master && i_wr && i_addr == `SPICR_A_DATA)
        begin
          sh_d = i_wdata;
          out_d = i_wdata[7];
          nss_d = 1'b0;
          st_d = st_run;
        end
        else if (en_q && !master && nss_prev_q && !s2_q[`SPICR_P_NSS])
        begin
          // Phase zero needs the first bit out before any clock edge
          sh_d = txb_q;
          out_d = txb_q[7];
          st_d = st_run;
        end
      end
      st_run:
      begin
        if (master)
        begin
          if (div_q == half - 9'h001)
          begin
            div_d = 9'h000;
            sck_d = ~sck_q;
            edge_ev = 1'b1;
          end
          else
          begin
            div_d = div_q + 9'h001;
          end
        end
        else
        begin
          // Slave follows the synchronised clock; two-flop delay bounds its rate
          edge_ev = s2_q[`SPICR_P_SCK] != sck_prev_q;
          if (s2_q[`SPICR_P_NSS])
          begin
            st_d = st_idle;
          end
        end
        if (edge_ev)
        begin
          cnt_d = cnt_q + 4'h1;
          if (samp)
          begin
            sh_d = {sh_q[6:0], din};
            // Slave sees edges late; next bit leaves at once to meet a tenth rate
            if (!master)
            begin
              out_d = sh_d[7];
            end
          end
          else
          begin
            out_d = sh_q[7];
          end
          if (cnt_q == 4'hf)
          begin
            fin = 1'b1;
            rx_d = sh_d;
            st_d = st_tail;
          end
        end
      end
      st_tail:
      begin
        if (master)
        begin
          if (div_q == half - 9'h001)
          begin
            nss_d = 1'b1;
            st_d = st_idle;
          end
          else
          begin
            div_d = div_q + 9'h001;
          end
        end
        else if (s2_q[`SPICR_P_NSS])
        begin
          st_d = st_idle;
        end
      end
      default:
      begin
        st_d = st_idle;
      end
    endcase
    // Clearing the enable drops any transfer; mode is then safe to change
    if (!en_q)
    begin
      st_d = st_idle;
      nss_d = 1'b1;
      sck_d = cpol;
    end
  end

  // Pin enables: master owns clock, data out and select; slave only its data
  always_comb
  begin
    oe_n_d = 4'hf;
    if (en_q && master)
    begin
      oe_n_d[`SPICR_P_SCK] = 1'b0;
      oe_n_d[`SPICR_P_MOSI] = 1'b0;
      oe_n_d[`SPICR_P_NSS] = 1'b0;
    end
    else if (en_q && !s2_q[`SPICR_P_NSS])
    begin
      oe_n_d[`SPICR_P_MISO] = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_q <= st_idle;
      div_q <= 9'h000;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      out_q <= 1'b0;
      sck_q <= 1'b0;
      nss_q <= 1'b1;
      rx_q <= 8'h00;
      oe_n_q <= 4'hf;
    end
    else
    begin
      st_q <= st_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      out_q <= out_d;
      sck_q <= sck_d;
      nss_q <= nss_d;
      rx_q <= rx_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Register file
  always_comb
  begin
    cfg_d = cfg_q;
    en_d = en_q;
    rate_d = rate_q;
    txb_d = txb_q;
    done_d = done_q;
    rdata_d = 8'h00;
    if (i_wr)
    begin
      case (i_addr)
        `SPICR_A_CFG: cfg_d = i_wdata & 8'h70;
        `SPICR_A_CTRL: en_d = i_wdata[`SPICR_B_EN];
        `SPICR_A_RATE: rate_d = i_wdata;
        default: txb_d = i_wdata;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        `SPICR_A_CFG: rdata_d = cfg_q;
        `SPICR_A_CTRL: rdata_d = {5'h00, done_q, st_q != st_idle, en_q};
        `SPICR_A_RATE: rdata_d = rate_q;
        default: rdata_d = rx_q;
      endcase
      if (i_addr == `SPICR_A_DATA)
      begin
        done_d = 1'b0;
      end
    end
    // A byte finishing in the clearing read is not lost
    if (fin)
    begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cfg_q <= `SPICR_RST_CFG;
      en_q <= 1'b0;
      rate_q <= `SPICR_RST_RATE;
      txb_q <= `SPICR_RST_TX;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      cfg_q <= cfg_d;
      en_q <= en_d;
      rate_q <= rate_d;
      txb_q <= txb_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign spi.dev_o = {nss_q, out_q, out_q, sck_q};
  assign spi.dev_oe_n = oe_n_q;
endmodule

// file: verilog/spicr_far.sv
// Far end of the serial link, master or slave by a user pin
`timescale 1ns/100ps
`include "spicr_consts.svh"
module spicr_far
  import spicr_pkg::*;
(
  // System
  input wire logic i_clk,
  input wire logic i_rst,
  // User side
  input wire logic i_master,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic [7:0] i_half,
  input wire logic i_start,
  input wire logic [7:0] i_tx,
  output logic [7:0] o_rx,
  output logic o_done,
  output logic o_busy,
  // Link
  spicr_if.oth spi
);
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic sck_prev_q;
  logic nss_prev_q;
  spicr_state_t st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] rx_q, rx_d;
  logic out_q, out_d;
  logic sck_q, sck_d;
  logic nss_q, nss_d;
  logic done_q, done_d;
  logic [3:0] oe_n_q, oe_n_d;
  logic [7:0] half;
  logic din;
  logic edge_ev;
  logic samp;

  // The user must pick a half period that keeps the device's slave limits
  assign half = (i_half == 8'h00) ? 8'h01 : i_half;
  assign din = i_master ? s2_q[`SPICR_P_MISO] : s2_q[`SPICR_P_MOSI];

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      sck_prev_q <= 1'b1;
      nss_prev_q <= 1'b1;
    end
    else
    begin
      s1_q <= spi.pin;
      s2_q <= s1_q;
      sck_prev_q <= s2_q[`SPICR_P_SCK];
      nss_prev_q <= s2_q[`SPICR_P_NSS];
    end
  end

  always_comb
  begin
    st_d = st_q;
    div_d = div_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    out_d = out_q;
    sck_d = sck_q;
    nss_d = nss_q;
    rx_d = rx_q;
    done_d = 1'b0;
    edge_ev = 1'b0;
    samp = i_cpha ? cnt_q[0] : ~cnt_q[0];
    oe_n_d = 4'hf;
    if (i_master)
    begin
      oe_n_d[`SPICR_P_SCK] = 1'b0;
      oe_n_d[`SPICR_P_MOSI] = 1'b0;
      oe_n_d[`SPICR_P_NSS] = 1'b0;
    end
    else if (!s2_q[`SPICR_P_NSS])
    begin
      oe_n_d[`SPICR_P_MISO] = 1'b0;
    end
    case (st_q)
      st_idle:
      begin
        sck_d = i_cpol;
        nss_d = 1'b1;
        div_d = 8'h00;
        cnt_d = 4'h0;
        if ((i_master && i_start) || (!i_master && nss_prev_q && !s2_q[`SPICR_P_NSS]))
        begin
          sh_d = i_tx;
          out_d = i_tx[7];
          nss_d = ~i_master;
          st_d = st_run;
        end
      end
      st_run:
      begin
        if (i_master)
        begin
          edge_ev = div_q == half - 8'h01;
          div_d = edge_ev ? 8'h00 : div_q + 8'h01;
          sck_d = sck_q ^ edge_ev;
        end
        else
        begin
          edge_ev = s2_q[`SPICR_P_SCK] != sck_prev_q;
          if (s2_q[`SPICR_P_NSS])
          begin
            st_d = st_idle;
          end
        end
        if (edge_ev)
        begin
          cnt_d = cnt_q + 4'h1;
          if (samp)
          begin
            sh_d = {sh_q[6:0], din};
          end
          else
          begin
            out_d = sh_q[7];
          end
          if (cnt_q == 4'hf)
          begin
            done_d = 1'b1;
            rx_d = sh_d;
            st_d = st_tail;
          end
        end
      end
      st_tail:
      begin
        if (i_master)
        begin
          div_d = div_q + 8'h01;
          if (div_q == half - 8'h01)
          begin
            nss_d = 1'b1;
            st_d = st_idle;
          end
        end
        else if (s2_q[`SPICR_P_NSS])
        begin
          st_d = st_idle;
        end
      end
      default:
      begin
        st_d = st_idle;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_q <= st_idle;
      div_q <= 8'h00;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      out_q <= 1'b0;
      sck_q <= 1'b0;
      nss_q <= 1'b1;
      done_q <= 1'b0;
      oe_n_q <= 4'hf;
    end
    else
    begin
      st_q <= st_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      out_q <= out_d;
      sck_q <= sck_d;
      nss_q <= nss_d;
      done_q <= done_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign o_rx = rx_q;
  assign o_done = done_q;
  assign o_busy = st_q != st_idle;
  assign spi.oth_o = {nss_q, out_q, out_q, sck_q};
  assign spi.oth_oe_n = oe_n_q;
endmodule

// file: test/spicr_monitor.sv
// Concurrent checks on the serial link pins
`timescale 1ns/100ps
module spicr_monitor (
  // System
  input wire logic i_clk,
  input wire logic i_rst,
  // Link
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe_n,
  input wire logic [3:0] oth_o,
  input wire logic [3:0] oth_oe_n,
  input wire logic [3:0] pin
);
  logic sck_prev_q, sck_prev_d, wire_prev_q, wire_prev_d;
  logic sel_prev_q, sel_prev_d, sck_fall_q, sck_fall_d;
  logic [7:0] gap_q, gap_d;
  logic [4:0] edge_q, edge_d;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Gap saturates so a long idle never wraps into a short one
  always_comb
  begin
    sck_prev_d = dev_o[0];
    wire_prev_d = pin[0];
    sel_prev_d = pin[3];
    gap_d = (dev_o[0] != sck_prev_q) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
    sck_fall_d = (sel_prev_q && !pin[3]) ? pin[0] : sck_fall_q;
    edge_d = pin[3] ? 5'h00 : edge_q + {4'h0, pin[0] != wire_prev_q};
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sck_prev_q <= 1'b0;
      wire_prev_q <= 1'b1;
      sel_prev_q <= 1'b1;
      sck_fall_q <= 1'b0;
      gap_q <= 8'h00;
      edge_q <= 5'h00;
    end
    else
    begin
      sck_prev_q <= sck_prev_d;
      wire_prev_q <= wire_prev_d;
      sel_prev_q <= sel_prev_d;
      sck_fall_q <= sck_fall_d;
      gap_q <= gap_d;
      edge_q <= edge_d;
    end
  end
  chk_no_contention: assert property ((~dev_oe_n & ~oth_oe_n) == 4'h0)
    else $error("both ends drive one pin");
  chk_idle_sck_hold: assert property (!dev_oe_n[0] && !$past(dev_oe_n[0]) && pin[3]
    && $past(pin[3]) |-> dev_o[0] == $past(dev_o[0])) else $error("idle clock moved");
  chk_rate_floor: assert property (!dev_oe_n[0] && !pin[3] && dev_o[0] != sck_prev_q
    |-> gap_q >= 8'h09) else $error("clock half too short");
  chk_first_edge_wait: assert property ($fell(pin[3]) && !dev_oe_n[0]
    |-> $stable(pin[0]) [*8]) else $error("first edge too early");
  chk_sck_quiet_sel: assert property ($rose(pin[3]) |-> $stable(pin[0]))
    else $error("clock edge at select release");
  chk_edge_count: assert property ($rose(pin[3]) |-> edge_q == 5'h10)
    else $error("frame edge count wrong");
  chk_sck_return: assert property ($rose(pin[3]) |-> pin[0] == sck_fall_q)
    else $error("clock not back at idle level");
  chk_miso_release: assert property ($rose(pin[3]) |-> ##[1:6] (dev_oe_n[2] && oth_oe_n[2]))
    else $error("data out held after select");
endmodule

// file: test/spi_clock_mode_and_rate_tb_top.sv
// Bench joining both link ends through the pin interface
`timescale 1ns/100ps
`include "spicr_consts.svh"
module spi_clock_mode_and_rate_tb_top;
  typedef struct packed {
    logic m;
    logic pol;
    logic pha;
    logic [7:0] rate;
    logic [7:0] half;
    logic [7:0] db;
    logic [7:0] fb;
  } spicr_row_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic master = 1'b0;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic [7:0] half = 8'h05;
  logic start = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx;
  logic done;
  int n_mismatch = 0;
  int check_count = 0;
  // Slave rows carry odd rates that the device must ignore
  spicr_row_t rows [8] = '{'{1, 0, 0, 8'h00, 8'h05, 8'hA5, 8'h3C},
    '{1, 0, 1, 8'h14, 8'h05, 8'h81, 8'h7E}, '{1, 1, 0, 8'h09, 8'h05, 8'h01, 8'hFE},
    '{1, 1, 1, 8'h03, 8'h05, 8'h5A, 8'hC3}, '{0, 0, 0, 8'hFF, 8'h05, 8'h96, 8'h69},
    '{0, 0, 1, 8'h00, 8'h05, 8'h0F, 8'hF0}, '{0, 1, 0, 8'h40, 8'h07, 8'h33, 8'hCC},
    '{0, 1, 1, 8'hFF, 8'h05, 8'hE7, 8'h18}};
  spicr_if link ();
  spicr_dev i_spicr_dev (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .spi(link));
  spicr_far i_spicr_far (.i_clk(i_clk), .i_rst(i_rst), .i_master(master), .i_cpol(cpol),
    .i_cpha(cpha), .i_half(half), .i_start(start), .i_tx(tx), .o_rx(rx), .o_done(done),
    .o_busy(), .spi(link));
  spicr_monitor i_spicr_monitor (.i_clk(i_clk), .i_rst(i_rst), .dev_o(link.dev_o),
    .dev_oe_n(link.dev_oe_n), .oth_o(link.oth_o), .oth_oe_n(link.oth_oe_n), .pin(link.pin));
  always #2 i_clk = ~i_clk;
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 1000; k++)
    begin
      @(posedge i_clk);
      #1;
      if (done === 1'b1)
        break;
    end
    if (k == 1000)
      check("done", 16'h0000, 16'h0001);
  endtask
  task automatic run_row(input spicr_row_t r, input logic duplex);
    logic [7:0] d;
    int n;
    int h;
    h = (r.rate < 8'h09) ? 10 : r.rate + 1;
    @(posedge i_clk);
    master <= 1'b0;
    cpol <= r.pol;
    cpha <= r.pha;
    half <= r.half;
    tx <= r.fb;
    wr_reg(`SPICR_A_CTRL, 8'h00);
    wr_reg(`SPICR_A_CFG, {1'b0, r.m, r.pha, r.pol, 4'h0});
    wr_reg(`SPICR_A_RATE, r.rate);
    wr_reg(`SPICR_A_CTRL, 8'h01);
    wr_reg(`SPICR_A_DATA, r.db);
    if (r.m)
    begin
      #1;
      n = 0;
      while (link.pin[3] !== 1'b1 && n < 2000)
      begin
        @(posedge i_clk);
        #1;
        n++;
      end
      check("frame", n[15:0], 16'(17 * h));
    end
    else
    begin
      @(posedge i_clk);
      master <= 1'b1;
      repeat (4) @(posedge i_clk);
      start <= 1'b1;
      @(posedge i_clk);
      start <= 1'b0;
      wait_done();
    end
    repeat (30) @(posedge i_clk);
    if (duplex)
      check("far_rx", {8'h00, rx}, {8'h00, r.db});
    rd_reg(`SPICR_A_DATA, d);
    check("dev_rx", {8'h00, d}, {8'h00, r.fb});
    check("sck_idle", {15'h0000, link.pin[0]}, {15'h0000, r.pol});
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    logic [7:0] d;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rows[i])
      run_row(rows[i], 1'b1);
    // Receive-only slave at the fastest rate it must accept
    run_row('{0, 1, 0, 8'h00, 8'h02, 8'h00, 8'hB4}, 1'b0);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    check("oe_n", {12'h000, link.dev_oe_n}, 16'h000f);
    rd_reg(`SPICR_A_CFG, d);
    check("cfg", {8'h00, d}, {8'h00, `SPICR_RST_CFG});
    rd_reg(`SPICR_A_RATE, d);
    check("rate", {8'h00, d}, {8'h00, `SPICR_RST_RATE});
    rd_reg(`SPICR_A_CTRL, d);
    check("ctrl", {8'h00, d}, 16'h0000);
    final_report();
  end
endmodule
